// ==== src/boot_rx_pkg.sv ====
package boot_rx_pkg;

  // Register map, word-indexed byte addresses
  localparam logic [7:0]  ADDR_LINK_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_BOOT_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_DMA_INDEX    = 8'h08;
  localparam logic [7:0]  ADDR_DMA_COUNT    = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_ROUTE    = 8'h10;

  // Link control field positions and reset value
  localparam int          PORT_ENABLE_BIT   = 0;
  localparam int          PORT_DMA_EN_BIT   = 1;
  localparam int          DMA_CHAIN_BIT     = 2;
  localparam int          DIRECTION_BIT     = 3;
  localparam int          HANG_DISABLE_BIT  = 7;
  localparam int          CHAN_IRQ_UNMASK   = 10;
  localparam logic [31:0] LINK_CTRL_RESET   = 32'h0000_0403;
  localparam logic [31:0] LINK_CTRL_WMASK   = 32'h0000_1f8f;

  // Boot select encodings
  localparam logic [2:0]  BOOT_SEL_LINK     = 3'h4;

  // DMA defaults
  localparam logic [19:0] VECTOR_TABLE_BASE = 20'h9_0000;
  localparam logic [19:0] DMA_STEP          = 20'h0_0001;
  localparam logic [15:0] DMA_WORD_COUNT    = 16'h0180;

  // Serial master framing
  localparam logic [31:0] READ_CMD_WORD     = 32'h0000_00c0; // opcode LSB first, zero address
  localparam int          WORD_BITS         = 32;
  localparam logic [7:0]  SERIAL_DIV_HALF   = 8'h64;          // Half period in clocks

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_CMD     = 5'b00010,
    ST_DATA    = 5'b00100,
    ST_LINK    = 5'b01000,
    ST_DONE    = 5'b10000
  } boot_state_e;

  // Memory write carrier
  typedef struct packed {
    logic        valid;
    logic [19:0] addr;
    logic [31:0] data;
  } mem_write_s;

endpackage

// ==== src/boot_stream_receiver.sv ====
`timescale 1ns/10ps
`default_nettype none

module boot_stream_receiver
  import boot_rx_pkg::*;
(
  input  wire logic        clk_in,            // Core clock
  input  wire logic        reset_n_in,        // Async reset, active low
  input  wire logic [2:0]  boot_select_pins_in, // Boot configuration straps
  input  wire logic        serial_miso_in,    // Serial data from slave
  output logic             serial_clock_out,  // Serial clock, idles high
  output logic             serial_select_n_out, // Slave select, active low
  output logic             serial_mosi_out,   // Serial data to slave
  input  wire logic        link_clock_in,     // Link port 0 clock from host
  input  wire logic [7:0]  link_data_pins_in, // Link port 0 data
  output logic             link_ack_out,      // Link port 0 acknowledge
  output mem_write_s       mem_wr_out,        // Internal memory write
  output logic             shared_port_irq_out, // Shared interrupt line
  output logic             serial_high_prio_irq_out, // Serial interrupt
  input  wire logic [7:0]  reg_addr_in,       // Register byte address
  input  wire logic [31:0] reg_wdata_in,      // Register write data
  input  wire logic        reg_write_in,      // Write strobe
  input  wire logic        reg_read_in,       // Read strobe
  output logic [31:0]      reg_rdata_out      // Read data, one cycle later
);

  boot_state_e state_reg;
  logic [31:0] link_ctrl_reg;
  logic [2:0]  boot_sel_reg;
  logic        strap_taken_reg;
  logic        link_route_reg;
  logic [19:0] dma_index_reg;
  logic [15:0] dma_count_reg;
  logic        done_reg;
  logic [7:0]  div_cnt_reg;
  logic [5:0]  bit_cnt_reg;
  logic [31:0] tx_shift_reg;
  logic [31:0] rx_shift_reg;
  logic [1:0]  miso_sync_reg;
  logic [1:0]  lclk_sync_reg;
  logic        lclk_prev_reg;
  logic [7:0]  ldat_sync0_reg;
  logic [7:0]  ldat_sync1_reg;
  logic [2:0]  sel_sync0_reg;
  logic [2:0]  sel_sync1_reg;
  logic [1:0]  strap_wait_reg;
  logic [23:0] pack_reg;
  logic [1:0]  byte_cnt_reg;
  logic [31:0] buf_data_reg [2];
  logic [1:0]  buf_valid_reg;
  logic        buf_rd_reg;
  logic        buf_wr_reg;
  mem_write_s  mem_wr_reg;
  logic [31:0] rdata_reg;
  logic        serial_edge;
  logic        lclk_rise;
  logic        word_take;
  logic [31:0] word_data;

  // Next DMA address after one step
  function automatic logic [19:0] step_addr(input logic [19:0] a);
    step_addr = a + DMA_STEP;
  endfunction

  // Input synchronisers; first stage feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      miso_sync_reg  <= 2'h0;
      lclk_sync_reg  <= 2'h0;
      lclk_prev_reg  <= 1'b0;
      ldat_sync0_reg <= 8'h00;
      ldat_sync1_reg <= 8'h00;
      sel_sync0_reg  <= 3'h0;
      sel_sync1_reg  <= 3'h0;
    end else begin
      sel_sync0_reg  <= boot_select_pins_in;
      sel_sync1_reg  <= sel_sync0_reg;
      miso_sync_reg  <= {miso_sync_reg[0], serial_miso_in};
      lclk_sync_reg  <= {lclk_sync_reg[0], link_clock_in};
      lclk_prev_reg  <= lclk_sync_reg[1];
      ldat_sync0_reg <= link_data_pins_in;
      ldat_sync1_reg <= ldat_sync0_reg;
    end
  end

  // Host toggling the link clock is the only start of a link transfer
  assign lclk_rise = lclk_sync_reg[1] & ~lclk_prev_reg;

  // Strap capture once the synchronised straps have settled after release
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_wait_reg  <= 2'h0;
      strap_taken_reg <= 1'b0;
      boot_sel_reg    <= 3'h0;
      link_route_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_wait_reg <= {strap_wait_reg[0], 1'b1};
      if (strap_wait_reg[1]) begin
        strap_taken_reg <= 1'b1;
        boot_sel_reg    <= sel_sync1_reg;
        link_route_reg  <= (sel_sync1_reg == BOOT_SEL_LINK);
      end
    end
  end

  // Serial clock divider, one-cycle enable per half period
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_reg <= 8'h00;
    end else if (div_cnt_reg == SERIAL_DIV_HALF - 8'h01) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end
  assign serial_edge = (div_cnt_reg == SERIAL_DIV_HALF - 8'h01);

  // Boot sequencing
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (strap_taken_reg) begin
            state_reg <= link_route_reg ? ST_LINK : ST_CMD;
          end
        end
        ST_CMD: begin
          if (serial_edge && serial_clock_out && bit_cnt_reg == 6'(WORD_BITS)) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA, ST_LINK: begin
          if (dma_count_reg == 16'h0000) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Serial master shifter: mode 3, LSB first, 32-bit words
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_clock_out <= 1'b1;
      bit_cnt_reg      <= 6'h00;
      tx_shift_reg     <= READ_CMD_WORD;
      rx_shift_reg     <= 32'h0000_0000;
    end else if (state_reg == ST_DATA && dma_count_reg == 16'h0000) begin
      // Park high as the frame closes, else the clock would sit low while deselected
      serial_clock_out <= 1'b1;
    end else if ((state_reg == ST_CMD || state_reg == ST_DATA) && serial_edge) begin
      serial_clock_out <= ~serial_clock_out;
      if (!serial_clock_out) begin
        // Rising edge samples the slave
        rx_shift_reg <= {miso_sync_reg[1], rx_shift_reg[31:1]};
        bit_cnt_reg  <= (bit_cnt_reg == 6'(WORD_BITS)) ? 6'h01 : bit_cnt_reg + 6'h01;
      end else if (bit_cnt_reg != 6'h00) begin
        // Falling edge presents next bit; zeros after command
        tx_shift_reg <= {1'b0, tx_shift_reg[31:1]};
      end
    end else if (word_take) begin
      bit_cnt_reg <= 6'h00;
    end
  end

  // Select held low for the whole serial boot
  assign serial_select_n_out = ~(state_reg == ST_CMD || state_reg == ST_DATA);
  assign serial_mosi_out     = tx_shift_reg[0];

  // Link byte packer, LSB byte first
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pack_reg     <= 24'h000000;
      byte_cnt_reg <= 2'h0;
      buf_wr_reg   <= 1'b0;
    end else begin
      buf_wr_reg <= 1'b0;
      if (state_reg == ST_LINK && lclk_rise && link_ctrl_reg[PORT_ENABLE_BIT]) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
        if (byte_cnt_reg == 2'h3) begin
          buf_wr_reg <= 1'b1;
        end else begin
          pack_reg <= {ldat_sync1_reg, pack_reg[23:8]};
        end
      end
    end
  end

  // Two-entry receive buffer; entry 0 drains first
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      buf_valid_reg   <= 2'h0;
      buf_data_reg[0] <= 32'h0000_0000;
      buf_data_reg[1] <= 32'h0000_0000;
    end else begin
      if (buf_rd_reg) begin
        buf_data_reg[0]  <= buf_data_reg[1];
        buf_valid_reg[0] <= buf_valid_reg[1];
        buf_valid_reg[1] <= 1'b0;
      end
      if (buf_wr_reg) begin
        if (!buf_valid_reg[0] || (buf_rd_reg && !buf_valid_reg[1])) begin
          buf_data_reg[0]  <= {ldat_sync1_reg, pack_reg};
          buf_valid_reg[0] <= 1'b1;
        end else begin
          buf_data_reg[1]  <= {ldat_sync1_reg, pack_reg};
          buf_valid_reg[1] <= 1'b1;
        end
      end
    end
  end
  assign buf_rd_reg   = buf_valid_reg[0] && link_ctrl_reg[PORT_DMA_EN_BIT];
  assign link_ack_out = ~buf_valid_reg[1];

  // Word source: link buffer or completed serial word after first one
  assign word_take = (state_reg == ST_LINK) ? buf_rd_reg :
                     (state_reg == ST_DATA && bit_cnt_reg == 6'(WORD_BITS) &&
                      serial_edge && serial_clock_out);
  assign word_data = (state_reg == ST_LINK) ? buf_data_reg[0] : rx_shift_reg;

  // DMA address and count; words written in order
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dma_index_reg <= VECTOR_TABLE_BASE;
      dma_count_reg <= DMA_WORD_COUNT;
      mem_wr_reg    <= '0;
      done_reg      <= 1'b0;
    end else begin
      mem_wr_reg.valid <= 1'b0;
      if (word_take && dma_count_reg != 16'h0000) begin
        mem_wr_reg.valid <= 1'b1;
        mem_wr_reg.addr  <= dma_index_reg;
        mem_wr_reg.data  <= word_data;
        dma_index_reg    <= step_addr(dma_index_reg);
        dma_count_reg    <= dma_count_reg - 16'h0001;
      end
      if (state_reg != ST_DONE && dma_count_reg == 16'h0000 &&
          (state_reg == ST_DATA || state_reg == ST_LINK)) begin
        done_reg <= 1'b1;
      end
    end
  end
  assign mem_wr_out = mem_wr_reg;

  // Completion interrupt routed by boot select
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shared_port_irq_out      <= 1'b0;
      serial_high_prio_irq_out <= 1'b0;
    end else begin
      shared_port_irq_out      <= done_reg && link_route_reg &&
                                  link_ctrl_reg[CHAN_IRQ_UNMASK];
      serial_high_prio_irq_out <= done_reg && !link_route_reg;
    end
  end

  // Link control register, software writable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_ctrl_reg <= LINK_CTRL_RESET;
    end else if (reg_write_in && reg_addr_in == ADDR_LINK_CTRL) begin
      link_ctrl_reg <= reg_wdata_in & LINK_CTRL_WMASK;
    end
  end

  // Register reads, one cycle latency; unmapped reads zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_LINK_CTRL:   rdata_reg <= link_ctrl_reg;
        ADDR_BOOT_STATUS: rdata_reg <= {24'h0, state_reg, boot_sel_reg};
        ADDR_DMA_INDEX:   rdata_reg <= {12'h000, dma_index_reg};
        ADDR_DMA_COUNT:   rdata_reg <= {16'h0000, dma_count_reg};
        ADDR_IRQ_ROUTE:   rdata_reg <= {30'h0, done_reg, link_route_reg};
        default:          rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign reg_rdata_out = rdata_reg;

endmodule

`default_nettype wire

// ==== verification/boot_rx_checker_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none

module boot_rx_checker
  import boot_rx_pkg::*;
(
  input  wire logic        clk_in,                   // Core clock
  input  wire logic        reset_n_in,               // Async reset, active low
  input  wire logic [2:0]  boot_select_pins_in,      // Boot straps
  input  wire logic        serial_clock_out,         // Serial clock
  input  wire logic        serial_select_n_out,      // Slave select
  input  wire logic        serial_mosi_out,          // Serial data out
  input  wire logic        link_ack_out,             // Link acknowledge
  input  wire mem_write_s  mem_wr_out,               // Memory write
  input  wire logic        shared_port_irq_out,      // Shared interrupt
  input  wire logic [7:0]  reg_addr_in,              // Register address
  input  wire logic        reg_write_in,             // Write strobe
  input  wire logic        reg_read_in,              // Read strobe
  input  wire logic [31:0] reg_rdata_out             // Read data
);
  logic [15:0] wcnt;   // Words written since reset
  logic [5:0]  bitcnt; // Serial clock rises in frame
  logic        sclk_q; // Serial clock one cycle late
  logic        wrote;  // Control written since reset

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // Word count drives address and limit checks
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) wcnt <= 16'h0000;
    else if (mem_wr_out.valid) wcnt <= wcnt + 16'h0001;
  end

  // Rise counter, cleared whenever the slave is deselected
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) bitcnt <= 6'h00;
    else if (serial_select_n_out) bitcnt <= 6'h00;
    else if (serial_clock_out && !sclk_q && bitcnt < 6'h20) bitcnt <= bitcnt + 6'h01;
  end

  // Edge finder for the serial clock
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) sclk_q <= 1'b1;
    else sclk_q <= serial_clock_out;
  end

  // Reset value only holds until software writes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) wrote <= 1'b0;
    else if (reg_write_in && reg_addr_in == ADDR_LINK_CTRL) wrote <= 1'b1;
  end

  a_ack_reset: assert property ($rose(reset_n_in) |-> link_ack_out)
    else $error("ack low leaving reset");
  a_valid_pulse: assert property (mem_wr_out.valid |=> !mem_wr_out.valid)
    else $error("write valid longer than one cycle");
  a_addr_seq: assert property (mem_wr_out.valid |-> mem_wr_out.addr == VECTOR_TABLE_BASE + 20'(wcnt))
    else $error("write address out of sequence");
  a_word_limit: assert property (mem_wr_out.valid |-> wcnt < DMA_WORD_COUNT)
    else $error("too many words written");
  a_ctrl_reset: assert property (reg_read_in && reg_addr_in == ADDR_LINK_CTRL && !wrote
    |=> reg_rdata_out == LINK_CTRL_RESET)
    else $error("control reset value wrong");
  a_cmd_bits: assert property (!serial_select_n_out && serial_clock_out && !sclk_q && bitcnt < 6'h20
    |-> serial_mosi_out == READ_CMD_WORD[bitcnt[4:0]])
    else $error("command bit wrong");
  a_clk_idle: assert property (serial_select_n_out |-> serial_clock_out)
    else $error("serial clock moves while deselected");
  a_irq_link: assert property (shared_port_irq_out |-> boot_select_pins_in == BOOT_SEL_LINK)
    else $error("shared irq outside link boot");
  a_irq_done: assert property ($rose(shared_port_irq_out)
    |-> wcnt == DMA_WORD_COUNT || (mem_wr_out.valid && wcnt == DMA_WORD_COUNT - 16'h0001))
    else $error("shared irq before last word");

  c_word: cover property (mem_wr_out.valid);
  c_irq: cover property ($rose(shared_port_irq_out));
  c_ctrl: cover property (reg_read_in && reg_addr_in == ADDR_LINK_CTRL);
  c_frame: cover property ($fell(serial_select_n_out));
endmodule

bind boot_stream_receiver boot_rx_checker chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .boot_select_pins_in(boot_select_pins_in),
  .serial_clock_out(serial_clock_out), .serial_select_n_out(serial_select_n_out),
  .serial_mosi_out(serial_mosi_out), .link_ack_out(link_ack_out), .mem_wr_out(mem_wr_out),
  .shared_port_irq_out(shared_port_irq_out), .reg_addr_in(reg_addr_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out)
);

`default_nettype wire

// ==== verification/boot_host_slave.sv ====
`timescale 1ns/10ps
`default_nettype none

module boot_host_slave
  import boot_rx_pkg::*;
(
  input  wire logic       sclk_in,  // Serial clock from device
  input  wire logic       sel_n_in, // Slave select, active low
  input  wire logic [1:0] kind_in,  // Source: 0 host, 1 short PROM, 2 flash
  output var logic        miso_out  // Serial data to device
);
  int          idx; // Bit index into the stream
  logic [31:0] cur; // Word being shifted out

  // Data pattern, also used by the bench for expectations
  function automatic logic [31:0] pat(input int n);
    logic [15:0] m;
    m = 16'(n);
    return {~m, m} ^ 32'h5a3c_96e1;
  endfunction

  // Kernel-less stream closes with a zero tag and two zero message words
  function automatic logic [31:0] word_at(input int n);
    if (n >= int'(DMA_WORD_COUNT) - 3 && n < int'(DMA_WORD_COUNT))
      return 32'h0000_0000;
    return pat(n);
  endfunction

  initial begin
    idx = 0;
    miso_out = 1'b0;
  end

  // Pad word first (low bits zero for host, ones for PROM and flash), then data, LSB first on falling edge
  always @(negedge sclk_in) begin
    if (!sel_n_in) begin
      if (idx >= 32)
        cur = pat(idx / 32 - 1);
      else if (kind_in == 2'h0 || (kind_in == 2'h1 && idx >= 24))
        cur = 32'ha500_0000;
      else
        cur = 32'hffff_ffff;
      miso_out = cur[idx % 32];
      idx = idx + 1;
    end
  end

  // Released line flips so a stale bit cannot pass as data
  always @(posedge sel_n_in) begin
    idx = 0;
    miso_out = ~miso_out;
  end
endmodule

`default_nettype wire

// ==== verification/boot_stream_receiver_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end

module boot_stream_receiver_test;
  import boot_rx_pkg::*;
  logic        clk_in;
  logic        reset_n_in;
  logic [2:0]  boot_select_pins_in;
  logic        serial_miso_in;
  logic        serial_clock_out;
  logic        serial_select_n_out;
  logic        serial_mosi_out;
  logic        link_clock_in;
  logic [7:0]  link_data_pins_in;
  logic        link_ack_out;
  mem_write_s  mem_wr_out;
  logic        shared_port_irq_out;
  logic        serial_high_prio_irq_out;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic        reg_write_in;
  logic        reg_read_in;
  logic [31:0] reg_rdata_out;
  logic [31:0] w;
  logic [1:0]  src_kind;
  int          fail_count;
  int          compares;
  int          cycles;
  int          nwords;

  boot_stream_receiver uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .boot_select_pins_in(boot_select_pins_in),
    .serial_miso_in(serial_miso_in), .serial_clock_out(serial_clock_out),
    .serial_select_n_out(serial_select_n_out), .serial_mosi_out(serial_mosi_out),
    .link_clock_in(link_clock_in), .link_data_pins_in(link_data_pins_in), .link_ack_out(link_ack_out),
    .mem_wr_out(mem_wr_out), .shared_port_irq_out(shared_port_irq_out),
    .serial_high_prio_irq_out(serial_high_prio_irq_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out)
  );

  boot_host_slave partner (
    .sclk_in(serial_clock_out), .sel_n_in(serial_select_n_out), .kind_in(src_kind),
    .miso_out(serial_miso_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Every written word is checked against the stream that was sent
  always @(posedge clk_in) begin
    if (mem_wr_out.valid === 1'b1) begin
      `CHK("addr", VECTOR_TABLE_BASE + 20'(nwords), mem_wr_out.addr)
      `CHK("data", partner.word_at(nwords), mem_wr_out.data)
      nwords++;
    end
  end

  // Hang guard, about a quarter above the expected run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task do_reset(input logic [2:0] sel);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    boot_select_pins_in <= sel;
    nwords = 0;
    repeat (12) @(posedge clk_in);
    `CHK("ack", 1'b1, link_ack_out)
    reset_n_in <= 1'b1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 `CHK("reg", e, reg_rdata_out)
  endtask

  // One byte per link clock of 32 ns; clock stands low between frames
  task lbyte(input logic [7:0] b);
    link_data_pins_in <= b;
    repeat (4) @(posedge clk_in);
    link_clock_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    link_clock_in <= 0;
  endtask

  // Wait for n serial words after the dropped first word
  task serial_words(input int n);
    for (int k = 0; k < 7000 * (n + 1) && nwords < n; k++) @(posedge clk_in);
    `CHK("words", n, nwords)
  endtask

  initial begin
    reset_n_in = 1'b0;
    boot_select_pins_in = BOOT_SEL_LINK;
    src_kind = 2'h0;
    link_clock_in = 1'b0;
    link_data_pins_in = 8'h00;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    // Link boot: full transfer, then one surplus word that must be ignored
    do_reset(BOOT_SEL_LINK);
    rd_chk(ADDR_LINK_CTRL, LINK_CTRL_RESET);
    rd_chk(ADDR_DMA_INDEX, {12'h000, VECTOR_TABLE_BASE});
    rd_chk(ADDR_DMA_COUNT, {16'h0000, DMA_WORD_COUNT});
    @(posedge clk_in);
    for (int i = 0; i < 385; i++) begin
      w = partner.word_at(i);
      for (int b = 0; b < 4; b++) lbyte(w[8*b +: 8]);
    end
    link_data_pins_in <= ~link_data_pins_in;
    repeat (20) @(posedge clk_in);
    `CHK("words", 384, nwords)
    `CHK("p1i", 1'b1, shared_port_irq_out)
    `CHK("hi", 1'b0, serial_high_prio_irq_out)
    $display("test link boot done");
    // Serial master boot: register access, then first words after the pad
    do_reset(3'h0);
    rd_chk(ADDR_LINK_CTRL, LINK_CTRL_RESET);
    wr(ADDR_LINK_CTRL, 32'hffff_ffff);
    rd_chk(ADDR_LINK_CTRL, LINK_CTRL_WMASK);
    wr(ADDR_LINK_CTRL, LINK_CTRL_RESET);
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0000_0000);
    serial_words(3);
    `CHK("p1i", 1'b0, shared_port_irq_out)
    $display("test serial host boot done");
    // Short-address PROM, then flash; each reset lands in mid frame
    src_kind <= 2'h1;
    do_reset(3'h0);
    serial_words(1);
    $display("test serial prom boot done");
    src_kind <= 2'h2;
    do_reset(3'h0);
    serial_words(1);
    $display("test serial flash boot done");
    report_and_stop();
  end
endmodule

`default_nettype wire
